// >>> sim/sar_adc_sequencer_properties.sv
// Port-level checks of the converter sequencer, bound to its every instance.
// Assumes one clock domain and the register map of the shared package.
`default_nettype none

module sar_adc_sequencer_checker
    import adc_seq_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [7:0] sfr_addr, // Register address.
    input wire logic [7:0] sfr_wdata, // Write data.
    input wire logic sfr_wr, // Write strobe.
    input wire logic sfr_rd, // Read strobe.
    input wire logic [7:0] sfr_rdata, // Read data.
    input wire logic conv_irq_enable, // Interrupt enable.
    input wire logic comp_in, // Comparator decision.
    input wire analog_ctrl_t analog, // Control word to the analog core.
    input wire logic conv_irq_request, // Interrupt request.
    input wire logic conv_busy // Conversion running.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_start;
        sfr_wr && sfr_addr == OFS_AUX_CONTROL_ONE && sfr_wdata[POS_START_BIT] && !conv_busy;
    endsequence
    sequence s_sampling;
        (conv_busy && analog.sample_hold) [*8];
    endsequence

    a_start_begins_sample: assert property (s_start |=> s_sampling)
        else $error("start write did not begin sampling");
    a_busy_needs_start: assert property ($rose(conv_busy) |-> $past(sfr_wr))
        else $error("busy rose without a start write");
    a_hold_no_return: assert property (conv_busy && !analog.sample_hold |=> !analog.sample_hold)
        else $error("sampling resumed inside a conversion");
    // An abort write may end the sample phase early, so that edge is left out.
    a_msb_trial_first: assert property ($fell(analog.sample_hold) && conv_busy && !$past(sfr_wr)
        |-> analog.trial == 12'h800)
        else $error("first trial word is not the top bit");
    a_irq_needs_enable: assert property (!conv_irq_enable |-> !conv_irq_request)
        else $error("interrupt requested while disabled");
    a_irq_at_end: assert property ($rose(conv_irq_request) |-> $fell(conv_busy) ||
        $rose(conv_irq_enable))
        else $error("done flag set away from the end of a conversion");
    a_low_nibble_pad: assert property (sfr_rd && sfr_addr == OFS_RESULT_LOW
        |=> sfr_rdata[3:0] == 4'h0)
        else $error("unused low result bits not zero");
    a_rdata_stands: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_channel_write: assert property (sfr_wr && sfr_addr == OFS_CHANNEL_SELECT
        |=> {3'h0, analog.channel} == ($past(sfr_wdata) & 8'h1f))
        else $error("channel select not taken from the write");
    a_bandgap_auto: assert property (analog.channel == CHAN_BANDGAP |-> analog.bandgap_enable)
        else $error("bandgap off while selected");
    a_ref_write: assert property (sfr_wr && sfr_addr == OFS_AUX_CONFIG_THREE
        |=> {7'h0, analog.ref_select} == ($past(sfr_wdata) & 8'h01))
        else $error("reference select not taken from the write");
endmodule

bind sar_adc_sequencer sar_adc_sequencer_checker i_sar_adc_sequencer_checker (
    .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .conv_irq_enable(conv_irq_enable), .comp_in(comp_in), .analog(analog),
    .conv_irq_request(conv_irq_request), .conv_busy(conv_busy)
);

`default_nettype wire

// >>> sim/sar_adc_sequencer_test.sv
// Self-checking bench of the converter sequencer with an analog core model.
// Assumes package, design, checker and model are compiled before it.
`default_nettype none

`define check_eq(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module sar_adc_sequencer_test
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic conv_irq_enable = 1'b0;
    logic [11:0] vin = 12'h000;
    logic [7:0] sfr_rdata;
    logic comp_in;
    analog_ctrl_t analog;
    logic conv_irq_request;
    logic conv_busy;
    logic [7:0] rd_val;
    logic [11:0] last_res;
    logic ref_bit;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int sh_cnt = 0;
    logic [7:0] ofs [8] = '{OFS_OPTION_CONFIG, OFS_INTERRUPT_FLAG, OFS_RESULT_LOW,
        OFS_RESULT_HIGH, OFS_CHANNEL_SELECT, OFS_AUX_CONFIG_THREE, OFS_AUX_CONTROL_ONE, 8'h20};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};

    sar_adc_sequencer i_sar_adc_sequencer (
        .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .conv_irq_enable(conv_irq_enable), .comp_in(comp_in), .analog(analog),
        .conv_irq_request(conv_irq_request), .conv_busy(conv_busy)
    );
    sar_analog_model i_sar_analog_model (
        .clock(clock), .analog(analog), .vin(vin), .comp_in(comp_in)
    );

    initial
    begin
        forever #20 clock = ~clock;
    end

    // The longest run is well under this many cycles; beyond it the run has hung.
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (analog.sample_hold === 1'b1)
            sh_cnt <= sh_cnt + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask

    function automatic logic [11:0] sar_expect(input logic [11:0] level);
        logic [11:0] r;
        r = 12'h000;
        for (int b = 11; b >= 0; b--)
            if (level >= (r | (12'h001 << b)))
                r = r | (12'h001 << b);
        return r;
    endfunction

    task automatic convert(input logic [1:0] sel, input logic [11:0] level, input logic clr);
        int t0;
        int n;
        wr(OFS_OPTION_CONFIG, {4'h0, sel, 2'h0});
        conv_irq_enable <= 1'($urandom);
        vin <= level;
        rd(OFS_OPTION_CONFIG, rd_val);
        `check_eq(rd_val, {4'h0, sel, 2'h0})
        wr(OFS_AUX_CONTROL_ONE, 8'h10);
        #1;
        t0 = cyc;
        sh_cnt = 0;
        rd(OFS_INTERRUPT_FLAG, rd_val);
        `check_eq(rd_val[POS_DONE_FLAG], 1'b0)
        wr(OFS_AUX_CONTROL_ONE, 8'h10);
        #1;
        n = 0;
        while (conv_busy !== 1'b0 && n < 2000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        `check_eq(cyc - t0, 50 * (32 >> sel) + 2)
        `check_eq(sh_cnt, 26 * (32 >> sel) + 1)
        last_res = sar_expect(level);
        rd(OFS_INTERRUPT_FLAG, rd_val);
        `check_eq(rd_val[POS_DONE_FLAG], 1'b1)
        `check_eq(conv_irq_request, conv_irq_enable)
        rd(OFS_AUX_CONTROL_ONE, rd_val);
        `check_eq(rd_val, 8'h00)
        rd(OFS_RESULT_HIGH, rd_val);
        `check_eq(rd_val, last_res[11:4])
        rd(OFS_RESULT_LOW, rd_val);
        `check_eq(rd_val, {last_res[3:0], 4'h0})
        if (clr)
        begin
            wr(OFS_INTERRUPT_FLAG, 8'hff);
            rd(OFS_INTERRUPT_FLAG, rd_val);
            `check_eq(rd_val[POS_DONE_FLAG], 1'b1)
            wr(OFS_INTERRUPT_FLAG, 8'hef);
            rd(OFS_INTERRUPT_FLAG, rd_val);
            `check_eq(rd_val[POS_DONE_FLAG], 1'b0)
            `check_eq(conv_irq_request, 1'b0)
        end
    endtask

    initial
    begin
        void'($urandom(32'h0979925b));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rd(ofs[i], rd_val);
            `check_eq(rd_val, rv[i])
        end
        `check_eq(analog.ref_select, 1'b0)
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 24; c++)
            begin
                ref_bit = 1'($urandom);
                wr(OFS_AUX_CONFIG_THREE, {5'h0, f[0], 1'b0, ref_bit});
                wr(OFS_CHANNEL_SELECT, 8'(c));
                @(posedge clock);
                #1;
                `check_eq(analog.channel, 5'(c))
                `check_eq(analog.bandgap_enable, f[0] || c == 11)
                `check_eq(analog.ref_select, ref_bit)
            end
        wr(OFS_AUX_CONFIG_THREE, 8'h00);
        wr(OFS_CHANNEL_SELECT, 8'h1f);
        @(posedge clock);
        #1;
        `check_eq(analog.bandgap_enable, 1'b0)
        convert(2'b11, 12'h000, 1'b1);
        convert(2'b10, 12'hfff, 1'b0);
        convert(2'b01, 12'h800, 1'b1);
        convert(2'b00, 12'h7ff, 1'b0);
        for (int i = 0; i < 4; i++)
            convert(2'($urandom), 12'($urandom), 1'($urandom));
        vin <= ~last_res;
        wr(OFS_AUX_CONTROL_ONE, 8'h10);
        repeat (20) @(posedge clock);
        wr(OFS_AUX_CONTROL_ONE, 8'h00);
        @(posedge clock);
        #1;
        `check_eq(conv_busy, 1'b0)
        rd(OFS_INTERRUPT_FLAG, rd_val);
        `check_eq(rd_val[POS_DONE_FLAG], 1'b0)
        rd(OFS_RESULT_HIGH, rd_val);
        `check_eq(rd_val, last_res[11:4])
        close_out();
    end
endmodule

`default_nettype wire

// >>> sim/sar_analog_model.sv
// Behavioural analog core: input sample-and-hold plus comparator.
// Assumes the bench hands the input level over as a 12-bit code.
`default_nettype none

module sar_analog_model
    import adc_seq_pkg::*;
(
    input wire logic clock, // System clock.
    input wire analog_ctrl_t analog, // Control word from the sequencer.
    input wire logic [11:0] vin, // Input level as a code.
    output logic comp_in // High when the held level is at or above the trial.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] held_reg = 12'h000;
    logic junk_reg = 1'b0;

    // While sampling the comparator answer means nothing, so it toggles to expose misuse.
    always_ff @(posedge clock)
    begin
        junk_reg <= !junk_reg;
        if (analog.sample_hold)
            held_reg <= vin;
    end
    assign comp_in = analog.sample_hold ? junk_reg : (held_reg >= analog.trial);
endmodule

`default_nettype wire

// >>> src/adc_seq_pkg.sv
// Shared constants, types and decode helpers for the converter sequencer.
// Assumes an 8-bit special function register bus and a single 25 MHz clock.
`default_nettype none

package adc_seq_pkg;

    // Clock rate of the system clock.
    localparam int SYS_CLK_HZ = 25_000_000;
    // Highest converter clock software may select; kept for reference only.
    localparam int CONV_CLK_MAX_HZ = 1_000_000;

    // Register offsets on the special function register bus.
    localparam logic [7:0] OFS_OPTION_CONFIG = 8'h94;
    localparam logic [7:0] OFS_INTERRUPT_FLAG = 8'h95;
    localparam logic [7:0] OFS_RESULT_LOW = 8'haa;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'hab;
    localparam logic [7:0] OFS_CHANNEL_SELECT = 8'hb6;
    localparam logic [7:0] OFS_AUX_CONFIG_THREE = 8'hef;
    localparam logic [7:0] OFS_AUX_CONTROL_ONE = 8'hf8;

    // Field positions.
    localparam int POS_DIV_SELECT_LO = 2;
    localparam int POS_DONE_FLAG = 4;
    localparam int POS_START_BIT = 4;
    localparam int POS_BANDGAP_FORCE = 2;
    localparam int POS_REF_SELECT = 0;
    localparam int POS_RESULT_LOW_LO = 4;

    // Reset values.
    localparam logic [1:0] RST_DIV_SELECT = 2'h0;
    localparam logic [4:0] RST_CHANNEL = 5'h1f;
    localparam logic RST_REF_SELECT = 1'b0;
    localparam logic RST_BANDGAP_FORCE = 1'b0;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;

    // Channel codes with side effects.
    localparam logic [4:0] CHAN_BANDGAP = 5'h0b;
    localparam logic [4:0] CHAN_QUARTER_SUPPLY = 5'h17;

    // Conversion timing in converter clocks.
    localparam int RESULT_BITS = 12;
    localparam int TOTAL_TICKS = 50;
    localparam int TICKS_PER_BIT = 2;
    localparam int SAMPLE_TICKS = TOTAL_TICKS - TICKS_PER_BIT * RESULT_BITS;

    // Divider terminal counts: divide by 32, 16, 8 and 4.
    localparam logic [4:0] DIV_TERM_32 = 5'h1f;
    localparam logic [4:0] DIV_TERM_16 = 5'h0f;
    localparam logic [4:0] DIV_TERM_8 = 5'h07;
    localparam logic [4:0] DIV_TERM_4 = 5'h03;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_t;

    // Everything that steers the analog core.
    typedef struct packed {
        logic sample_hold;
        logic bandgap_enable;
        logic ref_select;
        logic [4:0] channel;
        logic [11:0] trial;
    } analog_ctrl_t;

    function automatic logic [4:0] div_terminal(input logic [1:0] sel);
        case (sel)
            2'b00: div_terminal = DIV_TERM_32;
            2'b01: div_terminal = DIV_TERM_16;
            2'b10: div_terminal = DIV_TERM_8;
            default: div_terminal = DIV_TERM_4;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> src/conv_clock_divider.sv
// Converter clock enable generator, one pulse every 32, 16, 8 or 4 clocks.
// Assumes the select is stable while a conversion runs.
`default_nettype none

module conv_clock_divider
    import adc_seq_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic restart, // Restart the count so ticks align to a start.
    input wire logic [1:0] div_select, // Divider select code.
    output logic tick // One-cycle converter clock enable.
);

    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic tick_next;

    always_comb
    begin
        count_next = count_reg + 5'h01;
        tick_next = 1'b0;
        if (restart)
        begin
            count_next = 5'h00;
        end
        else if (count_reg >= div_terminal(div_select))
        begin
            count_next = 5'h00;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= 5'h00;
            tick <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick <= tick_next;
        end
    end

endmodule

`default_nettype wire

// >>> src/sar_adc_sequencer.sv
// Control logic of the 12-bit successive-approximation converter: its
// special function registers, the sample phase and the result store.
// Assumes a simple SFR bus with one-cycle write and read strobes, and an
// analog core that follows the packed control word combinationally.
`default_nettype none

// Notes on behaviour
// - Converter clock is system clock divided by 32, 16, 8 or 4 per select.
// - Writing one to the start bit begins conversion; hardware clears it at end.
// - End of conversion sets done flag; interrupt requested only when enabled.
// - Done flag clears on a zero write to it or a one to start.
// - Flag register bits clear on zero writes; ones leave them unchanged.
// - A conversion takes 50 converter clocks, sample plus two per bit.
// - The result loads in the same cycle the done flag sets.
// - High byte holds bits 11..4; low holds bits 3..0 in bits 7..4.
// - Five-bit channel select over 24 sources, resets to all ones.
// - Selecting the bandgap channel enables the bandgap generator.
// - Bandgap force bit keeps the generator enabled regardless of channel.
// - Reference select bit resets to zero, picks supply or fixed 2.5V.
// - Start bit is bit 4 of aux control; zero write clears it.
// - Reference select zero means supply, one means the 2.5V reference.
module sar_adc_sequencer
    import adc_seq_pkg::*;
(
    input wire logic clock, // System clock, 25 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [7:0] sfr_addr, // Register address.
    input wire logic [7:0] sfr_wdata, // Write data.
    input wire logic sfr_wr, // Write strobe, one cycle.
    input wire logic sfr_rd, // Read strobe, one cycle.
    output logic [7:0] sfr_rdata, // Read data, valid the cycle after the strobe.
    input wire logic conv_irq_enable, // Converter interrupt enable.
    input wire logic comp_in, // Comparator decision from the analog core.
    output analog_ctrl_t analog, // Control word to the analog core.
    output logic conv_irq_request, // Interrupt request level.
    output logic conv_busy // High while a conversion runs.
);

    // Register state.
    logic [1:0] div_select_reg;
    logic [1:0] div_select_next;
    logic done_flag_reg;
    logic done_flag_next;
    logic start_bit_reg;
    logic start_bit_next;
    logic [4:0] channel_reg;
    logic [4:0] channel_next;
    logic bandgap_force_reg;
    logic bandgap_force_next;
    logic ref_select_reg;
    logic ref_select_next;
    logic [11:0] result_reg;
    logic [11:0] result_next;

    // Sequencer state.
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [5:0] sample_count_reg;
    logic [5:0] sample_count_next;
    logic sample_hold_reg;
    logic sample_hold_next;
    logic bandgap_enable_reg;
    logic bandgap_enable_next;

    // Read data.
    logic [7:0] rdata_next;

    // Decoded strobes and handshakes between the groups.
    logic wr_option;
    logic wr_flag;
    logic wr_channel;
    logic wr_aux_three;
    logic wr_aux_one;
    logic start_request;
    logic abort_request;
    logic conv_tick;
    logic sar_begin;
    logic sar_finished;
    logic [11:0] sar_trial;

    assign wr_option = sfr_wr && (sfr_addr == OFS_OPTION_CONFIG);
    assign wr_flag = sfr_wr && (sfr_addr == OFS_INTERRUPT_FLAG);
    assign wr_channel = sfr_wr && (sfr_addr == OFS_CHANNEL_SELECT);
    assign wr_aux_three = sfr_wr && (sfr_addr == OFS_AUX_CONFIG_THREE);
    assign wr_aux_one = sfr_wr && (sfr_addr == OFS_AUX_CONTROL_ONE);

    // A start while converting is ignored, so a stray write cannot corrupt
    // the bit decisions already under way.
    assign start_request = wr_aux_one && sfr_wdata[POS_START_BIT]
        && (state_reg == ST_IDLE);
    // Clearing the start bit by hand abandons the conversion; the previous
    // result stays in place.
    assign abort_request = wr_aux_one && !sfr_wdata[POS_START_BIT]
        && (state_reg != ST_IDLE) && !sar_finished;

    conv_clock_divider u_divider (
        .clock(clock),
        .rst(rst),
        .restart(start_request),
        .div_select(div_select_reg),
        .tick(conv_tick)
    );

    sar_bit_engine #(
        .WIDTH(RESULT_BITS)
    ) u_sar (
        .clock(clock),
        .rst(rst),
        .tick(conv_tick),
        .begin_conv(sar_begin),
        .abort(abort_request),
        .comp_in(comp_in),
        .trial(sar_trial),
        .finished(sar_finished)
    );

    // Register file.
    always_comb
    begin
        div_select_next = div_select_reg;
        done_flag_next = done_flag_reg;
        start_bit_next = start_bit_reg;
        channel_next = channel_reg;
        bandgap_force_next = bandgap_force_reg;
        ref_select_next = ref_select_reg;
        result_next = result_reg;

        if (wr_option)
        begin
            div_select_next = sfr_wdata[POS_DIV_SELECT_LO +: 2];
        end
        if (wr_channel)
        begin
            channel_next = sfr_wdata[4:0];
        end
        if (wr_aux_three)
        begin
            bandgap_force_next = sfr_wdata[POS_BANDGAP_FORCE];
            ref_select_next = sfr_wdata[POS_REF_SELECT];
        end

        // Flag clears first so that a completion in the same cycle wins.
        if (wr_flag && !sfr_wdata[POS_DONE_FLAG])
        begin
            done_flag_next = 1'b0;
        end
        if (start_request)
        begin
            start_bit_next = 1'b1;
            done_flag_next = 1'b0;
        end
        if (abort_request)
        begin
            start_bit_next = 1'b0;
        end
        if (sar_finished)
        begin
            start_bit_next = 1'b0;
            done_flag_next = 1'b1;
            result_next = sar_trial;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            div_select_reg <= RST_DIV_SELECT;
            done_flag_reg <= 1'b0;
            start_bit_reg <= 1'b0;
            channel_reg <= RST_CHANNEL;
            bandgap_force_reg <= RST_BANDGAP_FORCE;
            ref_select_reg <= RST_REF_SELECT;
            result_reg <= RST_RESULT;
        end
        else
        begin
            div_select_reg <= div_select_next;
            done_flag_reg <= done_flag_next;
            start_bit_reg <= start_bit_next;
            channel_reg <= channel_next;
            bandgap_force_reg <= bandgap_force_next;
            ref_select_reg <= ref_select_next;
            result_reg <= result_next;
        end
    end

    // Sequencer: sample for the ticks left over by the bit decisions, then
    // hand over to the bit engine for two ticks per bit.
    always_comb
    begin
        state_next = state_reg;
        sample_count_next = sample_count_reg;
        sample_hold_next = sample_hold_reg;
        sar_begin = 1'b0;
        // The bandgap follows the select and the force bit, so moving off its code turns it off unless forced.
        bandgap_enable_next = bandgap_force_next
            || (channel_next == CHAN_BANDGAP);

        case (state_reg)
            ST_IDLE:
            begin
                sample_hold_next = 1'b0;
                if (start_request)
                begin
                    state_next = ST_SAMPLE;
                    sample_count_next = 6'h00;
                    sample_hold_next = 1'b1;
                end
            end
            ST_SAMPLE:
            begin
                if (abort_request)
                begin
                    state_next = ST_IDLE;
                    sample_hold_next = 1'b0;
                end
                else if (conv_tick)
                begin
                    if (sample_count_reg == 6'(SAMPLE_TICKS - 1))
                    begin
                        state_next = ST_CONVERT;
                        sample_hold_next = 1'b0;
                        sar_begin = 1'b1;
                    end
                    else
                    begin
                        sample_count_next = sample_count_reg + 6'h01;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (sar_finished || abort_request)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                sample_hold_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            sample_count_reg <= 6'h00;
            sample_hold_reg <= 1'b0;
            bandgap_enable_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sample_count_reg <= sample_count_next;
            sample_hold_reg <= sample_hold_next;
            bandgap_enable_reg <= bandgap_enable_next;
        end
    end

    // Read data, registered one cycle after the strobe. Unused bits read zero.
    always_comb
    begin
        rdata_next = sfr_rdata;
        if (sfr_rd)
        begin
            rdata_next = RST_READ_DATA;
            case (sfr_addr)
                OFS_OPTION_CONFIG:
                    rdata_next[POS_DIV_SELECT_LO +: 2] = div_select_reg;
                OFS_INTERRUPT_FLAG:
                    rdata_next[POS_DONE_FLAG] = done_flag_reg;
                OFS_RESULT_LOW:
                    rdata_next[POS_RESULT_LOW_LO +: 4] = result_reg[3:0];
                OFS_RESULT_HIGH:
                    rdata_next = result_reg[11:4];
                OFS_CHANNEL_SELECT:
                    rdata_next[4:0] = channel_reg;
                OFS_AUX_CONFIG_THREE:
                begin
                    rdata_next[POS_BANDGAP_FORCE] = bandgap_force_reg;
                    rdata_next[POS_REF_SELECT] = ref_select_reg;
                end
                OFS_AUX_CONTROL_ONE:
                    rdata_next[POS_START_BIT] = start_bit_reg;
                default:
                    rdata_next = RST_READ_DATA;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= RST_READ_DATA;
        end
        else
        begin
            sfr_rdata <= rdata_next;
        end
    end

    assign analog.sample_hold = sample_hold_reg;
    assign analog.bandgap_enable = bandgap_enable_reg;
    assign analog.ref_select = ref_select_reg;
    assign analog.channel = channel_reg;
    assign analog.trial = sar_trial;
    assign conv_irq_request = done_flag_reg && conv_irq_enable;
    assign conv_busy = start_bit_reg;

endmodule

`default_nettype wire

// >>> src/sar_bit_engine.sv
// Successive-approximation bit engine: two converter clocks per bit, MSB first.
// Assumes the comparator answer is valid at the second tick of each bit.
`default_nettype none

module sar_bit_engine
    import adc_seq_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS
)
(
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic tick, // Converter clock enable.
    input wire logic begin_conv, // Load the first trial word.
    input wire logic abort, // Drop the conversion in progress.
    input wire logic comp_in, // High when the input is at or above the trial.
    output logic [WIDTH-1:0] trial, // Trial word to the comparator core.
    output logic finished // One-cycle pulse after the last bit decision.
);

    logic [WIDTH-1:0] trial_next;
    logic [$clog2(WIDTH)-1:0] index_reg;
    logic [$clog2(WIDTH)-1:0] index_next;
    logic phase_reg;
    logic phase_next;
    logic active_reg;
    logic active_next;
    logic finished_next;

    always_comb
    begin
        trial_next = trial;
        index_next = index_reg;
        phase_next = phase_reg;
        active_next = active_reg;
        finished_next = 1'b0;
        if (abort)
        begin
            active_next = 1'b0;
        end
        else if (begin_conv)
        begin
            trial_next = '0;
            trial_next[WIDTH-1] = 1'b1;
            index_next = ($clog2(WIDTH))'(WIDTH - 1);
            phase_next = 1'b0;
            active_next = 1'b1;
        end
        else if (active_reg && tick)
        begin
            if (!phase_reg)
            begin
                phase_next = 1'b1;
            end
            else
            begin
                trial_next[index_reg] = comp_in;
                phase_next = 1'b0;
                if (index_reg == '0)
                begin
                    active_next = 1'b0;
                    finished_next = 1'b1;
                end
                else
                begin
                    trial_next[index_reg - 1'b1] = 1'b1;
                    index_next = index_reg - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            trial <= '0;
            index_reg <= '0;
            phase_reg <= 1'b0;
            active_reg <= 1'b0;
            finished <= 1'b0;
        end
        else
        begin
            trial <= trial_next;
            index_reg <= index_next;
            phase_reg <= phase_next;
            active_reg <= active_next;
            finished <= finished_next;
        end
    end

endmodule

`default_nettype wire
